// ===== logic/ssp_spi_slave.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_spi_slave
	import ssp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic ctrlWrite,
	input wire ssp_ctrl_t ctrlWdata,
	input wire logic interruptEnable,
	input wire ssp_flags_t flagClear,
	input wire logic dataWrite,
	input wire logic [7:0] dataWdata,
	input wire logic dataRead,
	output logic [7:0] dataRdata,
	output logic [7:0] serialControlReg,
	output ssp_flags_t flags,
	output logic irqRequest,
	input wire logic sck,
	input wire logic mosi,
	input wire logic nss,
	output logic miso,
	output logic misoOe_n
);

	// ****************************************
	// Configuration and mode decode
	// ****************************************
	ssp_ctrl_t ctrl;
	ssp_mode_t mode;
	logic faultEvent;
	logic portEnPrev;

	always_comb begin
		if (ctrl.selectModeHi)
			mode = SSP_MASTER_ONLY;
		else if (ctrl.selectModeLo)
			mode = SSP_FOUR_WIRE;
		else
			mode = SSP_THREE_WIRE;
	end

	// ****************************************
	// Serial inputs into the core clock domain
	// ****************************************
	logic [2:0] pinLevel;
	logic [2:0] pinRise;
	logic [2:0] pinFall;

	// Select idles high so a fresh reset never reads as a falling select
	ssp_sync_edge #(
		.WIDTH(3)
	) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.clkEn(clkEn),
		.async({nss, mosi, sck}),
		.resetLevel(3'b100),
		.level(pinLevel),
		.rise(pinRise),
		.fall(pinFall)
	);

	logic sckRise;
	logic sckFall;
	logic mosiLevel;
	logic nssLevel;
	logic nssFall;
	assign sckRise = pinRise[0];
	assign sckFall = pinFall[0];
	assign mosiLevel = pinLevel[1];
	assign nssLevel = pinLevel[2];
	assign nssFall = pinFall[2];

	// Slave takes part only when enabled, not master, and selected in four-wire mode
	logic slaveActive;
	always_comb begin
		slaveActive = ctrl.portEnable && !ctrl.masterEnable;
		if (mode == SSP_FOUR_WIRE)
			slaveActive = slaveActive && !nssLevel;
		else if (mode == SSP_MASTER_ONLY)
			slaveActive = 1'b0;
	end

	// Leading edge leaves idle level; phase picks sample edge
	logic leadEdge;
	logic trailEdge;
	logic sampleEdge;
	logic driveEdge;
	assign leadEdge = ctrl.clkPolarity ? sckFall : sckRise;
	assign trailEdge = ctrl.clkPolarity ? sckRise : sckFall;
	assign sampleEdge = slaveActive && (ctrl.clkPhase ? trailEdge : leadEdge);
	assign driveEdge = slaveActive && (ctrl.clkPhase ? leadEdge : trailEdge);

	// Mode fault: a master sharing the bus sees select pulled low
	assign faultEvent = ctrl.portEnable && ctrl.masterEnable && (mode == SSP_THREE_WIRE) && nssFall;

	// ****************************************
	// Control register
	// ****************************************
	// Software writes win except that a fault forces both enables off
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl <= '{portEnable: RST_PORT_EN, masterEnable: RST_MASTER_EN, selectModeHi: RST_SEL_HI,
				selectModeLo: RST_SEL_LO, clkPolarity: 1'b0, clkPhase: 1'b0};
		end else if (clkEn) begin
			if (ctrlWrite)
				ctrl <= ctrlWdata;
			if (faultEvent) begin
				ctrl.masterEnable <= 1'b0;
				ctrl.portEnable <= 1'b0;
			end
		end
	end

	// ****************************************
	// Bit counter
	// ****************************************
	logic [CNT_W-1:0] bitCount;
	logic byteDone;
	logic counterClear;

	assign byteDone = sampleEdge && (bitCount == CNT_W'(BITS_PER_BYTE - 1));
	// Three-wire mode has no external resync; only a disabled port clears the count
	assign counterClear = !ctrl.portEnable || ((mode == SSP_FOUR_WIRE) && nssFall);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bitCount <= '0;
			portEnPrev <= 1'b0;
		end else if (clkEn) begin
			portEnPrev <= ctrl.portEnable;
			if (counterClear)
				bitCount <= '0;
			else if (byteDone)
				bitCount <= '0;
			else if (sampleEdge)
				bitCount <= bitCount + 1'b1;
		end
	end

	// ****************************************
	// Receive shift and buffer
	// ****************************************
	logic [7:0] rxShift;
	logic [7:0] rxBuffer;
	logic rxUnread;
	logic [7:0] rxByte;
	assign rxByte = {rxShift[6:0], mosiLevel};

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rxShift <= RST_DATA;
		end else if (clkEn && sampleEdge) begin
			rxShift <= rxByte;
		end
	end

	// New byte only lands when the old one was read; a read in the same cycle does not make room for it
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rxBuffer <= RST_DATA;
			rxUnread <= 1'b0;
		end else if (clkEn) begin
			if (byteDone && !rxUnread) begin
				rxBuffer <= rxByte;
				rxUnread <= 1'b1;
			end else if (dataRead) begin
				rxUnread <= 1'b0;
			end
		end
	end

	// Read data register comes from the receive buffer
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			dataRdata <= RST_DATA;
		else if (clkEn && dataRead)
			dataRdata <= rxBuffer;
	end

	// ****************************************
	// Transmit holding buffer and shift register
	// ****************************************
	logic [7:0] txHold;
	logic txHoldFull;
	logic [7:0] txShift;
	logic txShiftFull;
	logic collisionEvent;
	logic midByte;

	assign midByte = (bitCount != '0);
	assign collisionEvent = dataWrite && txHoldFull;

	// Direct load is deferred while a byte is on the wire, so MISO never jumps mid-byte
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			txHold <= RST_DATA;
			txHoldFull <= 1'b0;
			txShift <= RST_DATA;
			txShiftFull <= 1'b0;
		end else if (clkEn) begin
			if (byteDone) begin
				// Reload on the last sample edge of the byte
				if (txHoldFull) begin
					txShift <= txHold;
					txShiftFull <= 1'b1;
					txHoldFull <= 1'b0;
				end else begin
					txShiftFull <= 1'b0;
				end
			end else if (txHoldFull && !txShiftFull && !midByte) begin
				txShift <= txHold;
				txShiftFull <= 1'b1;
				txHoldFull <= 1'b0;
			end else if (driveEdge && !(ctrl.clkPhase == 1'b0 && bitCount == '0)) begin
				txShift <= {txShift[6:0], 1'b0};
			end
			if (dataWrite && !txHoldFull) begin
				txHold <= dataWdata;
				txHoldFull <= 1'b1;
			end
		end
	end

	// MISO driven only while this slave takes part in a transfer
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			miso <= 1'b0;
			misoOe_n <= 1'b1;
		end else if (clkEn) begin
			miso <= txShift[7];
			misoOe_n <= !slaveActive;
		end
	end

	// ****************************************
	// Sticky flags, set beats clear
	// ****************************************
	ssp_flags_t flagSet;
	always_comb begin
		flagSet.xferDone = byteDone;
		flagSet.writeCollision = collisionEvent;
		flagSet.modeFault = faultEvent;
		flagSet.rxOverrun = byteDone && rxUnread;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			flags <= '0;
		else if (clkEn)
			flags <= flagSet | (flags & ~flagClear);
	end

	// Interrupt request follows any set flag once enabled
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			irqRequest <= 1'b0;
		else if (clkEn)
			irqRequest <= interruptEnable && ((|flagSet) || (|(flags & ~flagClear)));
	end

	// ****************************************
	// Control register image
	// ****************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			serialControlReg <= '0;
		end else if (clkEn) begin
			serialControlReg[CTL_DONE_POS] <= flagSet.xferDone | (flags.xferDone & ~flagClear.xferDone);
			serialControlReg[CTL_COLL_POS] <= flagSet.writeCollision |
				(flags.writeCollision & ~flagClear.writeCollision);
			serialControlReg[CTL_FAULT_POS] <= flagSet.modeFault | (flags.modeFault & ~flagClear.modeFault);
			serialControlReg[CTL_OVR_POS] <= flagSet.rxOverrun | (flags.rxOverrun & ~flagClear.rxOverrun);
			serialControlReg[CTL_SELHI_POS] <= ctrl.selectModeHi;
			serialControlReg[CTL_SELLO_POS] <= ctrl.selectModeLo;
			serialControlReg[CTL_TXBUSY_POS] <= txShiftFull | txHoldFull;
			serialControlReg[CTL_EN_POS] <= ctrl.portEnable;
		end
	end

endmodule
`default_nettype wire

// ===== include/ssp_pkg.sv
package ssp_pkg;

	// ****************************************
	// Sizes and timing
	// ****************************************
	localparam int BITS_PER_BYTE = 8;
	localparam int CNT_W = 4;
	localparam int SYNC_STAGES = 2;
	localparam int NSS_LEAD_CYCLES = 2;

	// ****************************************
	// Control register field positions
	// ****************************************
	localparam int CTL_DONE_POS = 7;
	localparam int CTL_COLL_POS = 6;
	localparam int CTL_FAULT_POS = 5;
	localparam int CTL_OVR_POS = 4;
	localparam int CTL_SELHI_POS = 3;
	localparam int CTL_SELLO_POS = 2;
	localparam int CTL_TXBUSY_POS = 1;
	localparam int CTL_EN_POS = 0;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic RST_PORT_EN = 1'b0;
	localparam logic RST_MASTER_EN = 1'b0;
	localparam logic RST_SEL_HI = 1'b0;
	localparam logic RST_SEL_LO = 1'b1;
	localparam logic [7:0] RST_DATA = 8'h00;

	// Software-written configuration
	typedef struct packed {
		logic portEnable;
		logic masterEnable;
		logic selectModeHi;
		logic selectModeLo;
		logic clkPolarity;
		logic clkPhase;
	} ssp_ctrl_t;

	// Sticky status flags
	typedef struct packed {
		logic xferDone;
		logic writeCollision;
		logic modeFault;
		logic rxOverrun;
	} ssp_flags_t;

	// Slave operating mode decoded from the select bits
	typedef enum logic [1:0] {
		SSP_THREE_WIRE,
		SSP_FOUR_WIRE,
		SSP_MASTER_ONLY
	} ssp_mode_t;

endpackage

// ===== logic/ssp_sync_edge.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_sync_edge
	import ssp_pkg::*;
#(
	parameter int WIDTH = 2
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic [WIDTH-1:0] async,
	input wire logic [WIDTH-1:0] resetLevel,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] stable;
	logic [WIDTH-1:0] prev;
	logic primed;
	logic [1:0] warm;

	// The settled stage only reflects the pin after both stages have filled
	assign primed = (warm == 2'(SYNC_STAGES));

	// ****************************************
	// Two-flop synchroniser
	// ****************************************
	// First stage feeds only the second one
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			stable <= '0;
		end else if (clkEn) begin
			meta <= async;
			stable <= meta;
		end
	end

	// ****************************************
	// Edge detection on the settled value
	// ****************************************
	// Until primed, prev follows resetLevel so no false edge appears after reset
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prev <= '0;
			warm <= 2'h0;
			rise <= '0;
			fall <= '0;
			level <= '0;
		end else if (clkEn) begin
			if (!primed)
				warm <= warm + 2'h1;
			prev <= primed ? stable : resetLevel;
			level <= primed ? stable : resetLevel;
			rise <= primed ? (stable & ~prev) : '0;
			fall <= primed ? (~stable & prev) : '0;
		end
	end

endmodule
`default_nettype wire

// ===== tb/ssp_spi_slave_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_spi_slave_sva
	import ssp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic interruptEnable,
	input wire ssp_flags_t flagClear,
	input wire logic dataWrite,
	input wire logic [7:0] serialControlReg,
	input wire ssp_flags_t flags,
	input wire logic irqRequest,
	input wire logic sck,
	input wire logic nss,
	input wire logic misoOe_n
);
	// ****************************************
	// Port checks
	// ****************************************
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic sckQ;
	logic [3:0] quiet;

	// Cycles since the serial clock last moved; a byte may only end soon after an edge
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sckQ <= 1'b0;
			quiet <= 4'h0;
		end else begin
			sckQ <= sck;
			quiet <= (sck != sckQ) ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
		end
	end

	a_no_self_start: assert property ($rose(flags.xferDone) |-> quiet < 4'h8)
		else $error("byte ended without serial clock");
	a_image_flags: assert property (serialControlReg[7:4] == flags)
		else $error("control image flags differ");
	a_done_sticky: assert property (flags.xferDone && !flagClear.xferDone |=> flags.xferDone)
		else $error("done flag cleared by hardware");
	a_irq_gated: assert property (!interruptEnable ##1 !interruptEnable |-> !irqRequest)
		else $error("irq while disabled");
	a_coll_cause: assert property ($rose(flags.writeCollision) |-> $past(dataWrite))
		else $error("collision without write");
	a_ovr_done: assert property ($rose(flags.rxOverrun) |-> flags.xferDone)
		else $error("overrun outside byte end");
	a_fault_disables: assert property ($rose(flags.modeFault) |-> ##[0:2] !serialControlReg[0])
		else $error("port still enabled after fault");
	a_miso_released: assert property ((serialControlReg[3:2] == 2'h1 && nss) [*5] |-> misoOe_n)
		else $error("miso driven while deselected");
	cover property ($rose(flags.xferDone));
	cover property ($rose(flags.rxOverrun));
	cover property ($rose(flags.modeFault));
endmodule
bind ssp_spi_slave ssp_spi_slave_sva chk_u (.core_clk, .rst, .interruptEnable, .flagClear, .dataWrite,
	.serialControlReg, .flags, .irqRequest, .sck, .nss, .misoOe_n);
`default_nettype wire

// ===== tb/ssp_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_master_model (
	output logic sck,
	output logic mosi,
	output logic nss,
	input wire logic miso
);
	// ****************************************
	// Serial master, clock idle low
	// ****************************************
	initial begin
		sck = 1'b0;
		mosi = 1'b0;
		nss = 1'b1;
	end

	// Shifts n bits MSB first; sel low keeps select high, the only-slave case in three-wire use
	task automatic xfer(input logic sel, input int n, input logic [7:0] t, output logic [7:0] r);
		nss = !sel;
		#200;
		for (int i = 7; i > 7 - n; i--) begin
			mosi = t[i];
			#100 sck = 1'b1;
			#50 r[i] = miso;
			#50 sck = 1'b0;
		end
		mosi = ~mosi; // Stale bit never lingers
		#200 nss = 1'b1;
		#300;
	endtask
endmodule
`default_nettype wire

// ===== tb/ssp_spi_slave_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_spi_slave_tb
	import ssp_pkg::*;
;
	// ****************************************
	// Bench
	// ****************************************
	logic core_clk, rst, ctrlWrite, interruptEnable, dataWrite, dataRead, irqRequest;
	logic sck, mosi, nss, miso, misoOe_n;
	logic [7:0] dataWdata, dataRdata, serialControlReg, rx;
	ssp_ctrl_t ctrlWdata;
	ssp_flags_t flagClear, flags;
	int failCount, checked;

	ssp_spi_slave dut_u (.core_clk, .rst, .clkEn(1'b1), .ctrlWrite, .ctrlWdata, .interruptEnable, .flagClear,
		.dataWrite, .dataWdata, .dataRead, .dataRdata, .serialControlReg, .flags, .irqRequest, .sck, .mosi,
		.nss, .miso, .misoOe_n);
	ssp_master_model mst_u (.sck, .mosi, .nss, .miso);

	// 40 MHz system clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Drives land 2 ns after the edge so no sampling race
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			failCount++;
		end
	endtask
	task automatic ctl(input logic [3:0] m);
		ctrlWrite = 1'b1;
		ctrlWdata = {m, 2'h0};
		step(1);
		ctrlWrite = 1'b0;
		step(1);
	endtask
	task automatic wr(input logic [7:0] d);
		dataWrite = 1'b1;
		dataWdata = d;
		step(1);
		dataWrite = 1'b0;
		step(1);
	endtask
	task automatic rd(input logic [7:0] exp);
		dataRead = 1'b1;
		step(1);
		dataRead = 1'b0;
		step(1);
		chk("rx data", exp, dataRdata);
	endtask
	task automatic clr();
		flagClear = 4'hf;
		step(1);
		flagClear = 4'h0;
		step(2);
	endtask
	// Pin synchroniser needs a few cycles before flags settle
	task automatic xf(input logic s, input int n, input logic [7:0] t);
		mst_u.xfer(s, n, t, rx);
		step(6);
	endtask
	task automatic results();
		if (failCount == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		#2000000;
		failCount++;
		results();
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		{ctrlWrite, interruptEnable, dataWrite, dataRead} = 4'h0;
		ctrlWdata = 6'h04;
		flagClear = 4'h0;
		dataWdata = 8'h00;
		repeat (6) @(posedge core_clk);
		#2;
		rst = 1'b0;
		step(4);
		chk("control", 8'h04, serialControlReg);
		chk("miso oe", 8'h01, {7'h0, misoOe_n});
		ctl(4'h9);
		wr(8'ha5);
		wr(8'h3c);
		wr(8'h77);
		chk("flags", 8'h04, {4'h0, flags});
		xf(1'b1, 8, 8'h5a);
		chk("miso byte", 8'ha5, rx);
		chk("flags", 8'h0c, {4'h0, flags});
		rd(8'h5a);
		xf(1'b1, 8, 8'hc3);
		chk("miso byte", 8'h3c, rx);
		xf(1'b1, 8, 8'h11);
		rd(8'hc3);
		chk("flags", 8'h0d, {4'h0, flags});
		interruptEnable = 1'b1;
		step(2);
		chk("irq", 8'h01, {7'h0, irqRequest});
		clr();
		chk("irq", 8'h00, {7'h0, irqRequest});
		xf(1'b0, 8, 8'h42);
		chk("flags", 8'h00, {4'h0, flags});
		xf(1'b1, 3, 8'hff);
		xf(1'b1, 8, 8'h69);
		rd(8'h69);
		clr();
		ctl(4'h8);
		xf(1'b1, 3, 8'he0);
		xf(1'b1, 5, 8'h50);
		rd(8'hea);
		xf(1'b0, 3, 8'h00);
		ctl(4'h0);
		ctl(4'h8);
		xf(1'b0, 8, 8'h96);
		rd(8'h96);
		clr();
		ctl(4'hc);
		xf(1'b1, 0, 8'h00);
		chk("flags", 8'h02, {4'h0, flags});
		chk("enable", 8'h00, {7'h0, serialControlReg[0]});
		results();
	end
endmodule
`default_nettype wire
